// ===== hdl/scsi_capture_regs.svh
// Timing constants for the SCSI phase capture strobe block.
// Assumes a single 10 MHz system clock; all counts derive from it.
`ifndef SCSI_CAPTURE_REGS_SVH
`define SCSI_CAPTURE_REGS_SVH

// ----------------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    100
`define ARB_DELAY_NS     800
`define FREE_DELAY_NS    400
`define STROBE_DELAY_NS  40

// Least times round up to whole cycles
`define ARB_CYC    ((`ARB_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FREE_CYC   ((`FREE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC ((`STROBE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define CNT_W        4
`define BUF_DEPTH    2
`define PAR_ERR_RST  2'h0

`endif

// ===== hdl/scsi_capture_pkg.sv
// Types shared by the SCSI phase capture strobe block.
// Assumes bus lines arrive already converted to asserted-high levels.
package scsi_capture_pkg;

  // ----------------------------------------------------------------------
  // Bus lines as seen behind the receivers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  parity;
    logic        io;
    logic        cd;
    logic        msg;
    logic        sel;
    logic        bsy;
    logic        req;
    logic        ack;
    logic        atn;
    logic        rst;
  } scsi_bus_t;

  // ----------------------------------------------------------------------
  // Decoded bus phase
  // ----------------------------------------------------------------------
  typedef enum logic [8:0] {
    PH_FREE = 9'h001,
    PH_ARB  = 9'h002,
    PH_SEL  = 9'h004,
    PH_CMD  = 9'h008,
    PH_STAT = 9'h010,
    PH_MSG  = 9'h020,
    PH_DIN  = 9'h040,
    PH_DOUT = 9'h080,
    PH_RSVD = 9'h100
  } phase_t;

  // ----------------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_WATCH     = 8'h01,
    ST_FREE_CNT  = 8'h02,
    ST_FREE_DONE = 8'h04,
    ST_ARB_CNT   = 8'h08,
    ST_ARB_DONE  = 8'h10,
    ST_SEL_WAIT  = 8'h20,
    ST_SEL_END   = 8'h40,
    ST_XFER_WAIT = 8'h80
  } ctl_state_t;

  // ----------------------------------------------------------------------
  // One captured snapshot
  // ----------------------------------------------------------------------
  typedef struct packed {
    phase_t      phase;
    logic        wide;
    logic [15:0] data;
    logic [1:0]  parity;
    logic [1:0]  parErr;
    logic        io;
    logic        cd;
    logic        msg;
    logic        atn;
    logic        rst;
    logic        bsy;
    logic        sel;
  } snapshot_t;

endpackage : scsi_capture_pkg

// ===== hdl/bus_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes each bit is independent; skew between bits is not removed.
`timescale 1ns/100ps
module bus_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta_q[i]  <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          meta_q[i]  <= asyncIn[i];
          syncOut[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : bus_sync

// ===== hdl/capture_buffer.sv
// Two-entry buffer between snapshot source and capture instrument.
// Assumes the consumer may stall; a full buffer drops inReady.
`timescale 1ns/100ps
module capture_buffer (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Filling side
  input  wire logic                         inValid,
  output logic                              inReady,
  input  wire scsi_capture_pkg::snapshot_t  inWord,
  // Draining side
  output logic                              outValid,
  input  wire logic                         outReady,
  output scsi_capture_pkg::snapshot_t       outWord
);

  logic                        skidValid_q;
  scsi_capture_pkg::snapshot_t skidWord_q;
  logic                        push;
  logic                        pop;

  assign inReady = !skidValid_q;
  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;

  // Output stage always registered; second entry only on a stall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outValid    <= 1'b0;
      outWord     <= '0;
      skidValid_q <= 1'b0;
      skidWord_q  <= '0;
    end else if (!outValid || pop) begin
      if (skidValid_q) begin
        outValid    <= 1'b1;
        outWord     <= skidWord_q;
        skidValid_q <= 1'b0;
      end else begin
        outValid <= push;
        outWord  <= inWord;
      end
    end else if (push) begin
      skidValid_q <= 1'b1;
      skidWord_q  <= inWord;
    end
  end

endmodule : capture_buffer

// ===== hdl/scsi_phase_capture_strobe.sv
// Passive SCSI phase monitor: latches bus lines and strobes snapshots.
// Assumes asserted-high bus lines from receivers, asynchronous to clk,
// and a 10 MHz clock; no SCSI line is ever driven.
//
// Functional notes
// - Latch data, parity, parity errors, phase lines together
// - ATN, RST, BSY, SEL taken at strobe
// - One strobe yields one coherent snapshot
// - Arbitration: sample 800 ns, strobe 40 ns later
// - Selection: latch BSY negate, strobe BSY reassert
// - Command/status/message: latch REQ rise, strobe ACK fall
// - Data in: latch REQ rise, strobe REQ fall
// - Data out: latch ACK rise, strobe ACK fall
// - Bus free: wait 400 ns, latch, strobe 40 ns
// - Bus-free snapshot carries RST state
// - Reset during bus free: latch, strobe 40 ns
// - RST sampled with other lines while active
// - Timing path passes all lines unlatched
// - Works on 8-bit or 16-bit bus
// - Parity error only when mismatch and enabled
`timescale 1ns/100ps
`include "scsi_capture_regs.svh"
module scsi_phase_capture_strobe (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Observed bus lines, asynchronous
  input  wire scsi_capture_pkg::scsi_bus_t  scsiBus,
  // Front-panel settings, asynchronous
  input  wire logic                         wideBus,
  input  wire logic                         parityCheckEn,
  // Snapshot stream to the capture instrument
  output logic                              capValid,
  input  wire logic                         capReady,
  output scsi_capture_pkg::snapshot_t       capWord,
  output logic                              capOverrun,
  // Timing path
  output scsi_capture_pkg::scsi_bus_t       timingBus
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic scsi_capture_pkg::phase_t decodePhase(
    input scsi_capture_pkg::scsi_bus_t b);
    scsi_capture_pkg::phase_t p;
    p = scsi_capture_pkg::PH_RSVD;
    if (!b.bsy && !b.sel) begin
      p = scsi_capture_pkg::PH_FREE;
    end else if (b.sel && !b.bsy) begin
      p = scsi_capture_pkg::PH_SEL;
    end else if (b.sel) begin
      p = scsi_capture_pkg::PH_ARB;
    end else begin
      case ({b.msg, b.cd, b.io})
        3'h0:    p = scsi_capture_pkg::PH_DOUT;
        3'h1:    p = scsi_capture_pkg::PH_DIN;
        3'h2:    p = scsi_capture_pkg::PH_CMD;
        3'h3:    p = scsi_capture_pkg::PH_STAT;
        3'h6:    p = scsi_capture_pkg::PH_MSG;
        3'h7:    p = scsi_capture_pkg::PH_MSG;
        default: p = scsi_capture_pkg::PH_RSVD;
      endcase
    end
    return p;
  endfunction : decodePhase

  // Odd parity over one byte; high means mismatch
  function automatic logic parityBad(input logic [7:0] d, input logic p);
    return !(^{d, p});
  endfunction : parityBad

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  localparam int BUS_W = $bits(scsi_capture_pkg::scsi_bus_t);

  logic [BUS_W-1:0]             busRaw;
  logic [1:0]                   cfgRaw;
  scsi_capture_pkg::scsi_bus_t  busS;
  scsi_capture_pkg::scsi_bus_t  busP_q;
  logic                         wideS;
  logic                         parEnS;

  bus_sync #(.WIDTH(BUS_W)) u_bus_sync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (scsiBus),
    .syncOut (busRaw)
  );

  bus_sync #(.WIDTH(2)) u_cfg_sync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn ({wideBus, parityCheckEn}),
    .syncOut (cfgRaw)
  );

  assign busS   = scsi_capture_pkg::scsi_bus_t'(busRaw);
  assign wideS  = cfgRaw[1];
  assign parEnS = cfgRaw[0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busP_q <= '0;
    end else begin
      busP_q <= busS;
    end
  end

  // ----------------------------------------------------------------------
  // Edge and phase decode
  // ----------------------------------------------------------------------
  logic                      busFree;
  logic                      arbBoth;
  logic                      bsyRise;
  logic                      bsyFall;
  logic                      reqRise;
  logic                      reqFall;
  logic                      ackRise;
  logic                      ackFall;
  logic                      rstRise;
  scsi_capture_pkg::phase_t  phaseNow;

  assign busFree  = !busS.bsy && !busS.sel;
  assign arbBoth  = busS.bsy && busS.sel;
  assign bsyRise  = busS.bsy && !busP_q.bsy;
  assign bsyFall  = !busS.bsy && busP_q.bsy;
  assign reqRise  = busS.req && !busP_q.req;
  assign reqFall  = !busS.req && busP_q.req;
  assign ackRise  = busS.ack && !busP_q.ack;
  assign ackFall  = !busS.ack && busP_q.ack;
  assign rstRise  = busS.rst && !busP_q.rst;
  assign phaseNow = decodePhase(busS);

  // ----------------------------------------------------------------------
  // Phase tracking state machine
  // ----------------------------------------------------------------------
  scsi_capture_pkg::ctl_state_t  state_q;
  scsi_capture_pkg::ctl_state_t  state_d;
  scsi_capture_pkg::phase_t      kind_q;
  scsi_capture_pkg::phase_t      kind_d;
  logic [`CNT_W-1:0]             cnt_q;
  logic [`CNT_W-1:0]             cnt_d;
  logic                          latchNow;
  logic                          timedLatch;
  logic                          edgeFire;
  logic                          fireAll;

  localparam logic [`CNT_W-1:0] ARB_LAST  = `CNT_W'(`ARB_CYC - 1);
  localparam logic [`CNT_W-1:0] FREE_LAST = `CNT_W'(`FREE_CYC - 1);

  always_comb begin
    state_d    = state_q;
    kind_d     = kind_q;
    cnt_d      = cnt_q;
    latchNow   = 1'b0;
    timedLatch = 1'b0;
    edgeFire   = 1'b0;
    unique case (state_q)
      scsi_capture_pkg::ST_WATCH: begin
        cnt_d = '0;
        if (busFree) begin
          state_d = scsi_capture_pkg::ST_FREE_CNT;
        end else if (arbBoth) begin
          state_d = scsi_capture_pkg::ST_ARB_CNT;
        end else if (bsyFall && busS.sel) begin
          latchNow = 1'b1;
          state_d  = scsi_capture_pkg::ST_SEL_WAIT;
        end else if (phaseNow == scsi_capture_pkg::PH_DOUT && ackRise) begin
          latchNow = 1'b1;
          kind_d   = phaseNow;
          state_d  = scsi_capture_pkg::ST_XFER_WAIT;
        end else if (phaseNow != scsi_capture_pkg::PH_DOUT &&
                     phaseNow != scsi_capture_pkg::PH_RSVD && reqRise) begin
          latchNow = 1'b1;
          kind_d   = phaseNow;
          state_d  = scsi_capture_pkg::ST_XFER_WAIT;
        end
      end
      scsi_capture_pkg::ST_FREE_CNT: begin
        if (!busFree) begin
          state_d = scsi_capture_pkg::ST_WATCH;
        end else if (cnt_q == FREE_LAST) begin
          latchNow   = 1'b1;
          timedLatch = 1'b1;
          state_d    = scsi_capture_pkg::ST_FREE_DONE;
        end else begin
          cnt_d = cnt_q + `CNT_W'(1);
        end
      end
      scsi_capture_pkg::ST_FREE_DONE: begin
        if (!busFree) begin
          state_d = scsi_capture_pkg::ST_WATCH;
        end else if (rstRise) begin
          latchNow   = 1'b1;
          timedLatch = 1'b1;
        end
      end
      scsi_capture_pkg::ST_ARB_CNT: begin
        if (bsyFall && busS.sel) begin
          latchNow = 1'b1;
          state_d  = scsi_capture_pkg::ST_SEL_WAIT;
        end else if (!arbBoth) begin
          state_d = scsi_capture_pkg::ST_WATCH;
        end else if (cnt_q == ARB_LAST) begin
          latchNow   = 1'b1;
          timedLatch = 1'b1;
          state_d    = scsi_capture_pkg::ST_ARB_DONE;
        end else begin
          cnt_d = cnt_q + `CNT_W'(1);
        end
      end
      scsi_capture_pkg::ST_ARB_DONE: begin
        if (bsyFall && busS.sel) begin
          latchNow = 1'b1;
          state_d  = scsi_capture_pkg::ST_SEL_WAIT;
        end else if (!busS.sel) begin
          state_d = scsi_capture_pkg::ST_WATCH;
        end
      end
      scsi_capture_pkg::ST_SEL_WAIT: begin
        if (bsyRise) begin
          edgeFire = 1'b1;
          state_d  = scsi_capture_pkg::ST_SEL_END;
        end else if (!busS.sel) begin
          state_d = scsi_capture_pkg::ST_WATCH;
        end
      end
      scsi_capture_pkg::ST_SEL_END: begin
        // BSY and SEL overlap after selection; not a new arbitration
        if (!busS.sel) begin
          state_d = scsi_capture_pkg::ST_WATCH;
        end
      end
      scsi_capture_pkg::ST_XFER_WAIT: begin
        if (kind_q == scsi_capture_pkg::PH_DIN ? reqFall : ackFall) begin
          edgeFire = 1'b1;
          state_d  = scsi_capture_pkg::ST_WATCH;
        end else if (!busS.bsy) begin
          state_d = scsi_capture_pkg::ST_WATCH;
        end
      end
      default: begin
        state_d = scsi_capture_pkg::ST_WATCH;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= scsi_capture_pkg::ST_WATCH;
      kind_q  <= scsi_capture_pkg::PH_FREE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Strobe delay after timed latches
  // ----------------------------------------------------------------------
  // 40 ns rounds up to one clock; a finer timebase would need a faster clk
  logic [`STROBE_CYC-1:0] fireDly_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fireDly_q <= '0;
    end else begin
      fireDly_q <= `STROBE_CYC'({fireDly_q, timedLatch});
    end
  end

  assign fireAll = edgeFire || fireDly_q[`STROBE_CYC-1];

  // ----------------------------------------------------------------------
  // Latched group
  // ----------------------------------------------------------------------
  logic [15:0]              latData_q;
  logic [1:0]               latPar_q;
  logic [1:0]               latParErr_q;
  logic [2:0]               latPhase_q;
  scsi_capture_pkg::phase_t latDecoded_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latData_q    <= '0;
      latPar_q     <= '0;
      latParErr_q  <= `PAR_ERR_RST;
      latPhase_q   <= '0;
      latDecoded_q <= scsi_capture_pkg::PH_FREE;
    end else if (latchNow) begin
      latData_q      <= busS.data;
      latPar_q       <= busS.parity;
      latPhase_q     <= {busS.io, busS.cd, busS.msg};
      latDecoded_q   <= phaseNow;
      latParErr_q[0] <= parEnS && parityBad(busS.data[7:0], busS.parity[0]);
      latParErr_q[1] <= parEnS && wideS &&
                        parityBad(busS.data[15:8], busS.parity[1]);
    end
  end

  // ----------------------------------------------------------------------
  // Snapshot assembly and buffer
  // ----------------------------------------------------------------------
  scsi_capture_pkg::snapshot_t  pushWord;
  logic                         bufReady;

  always_comb begin
    pushWord        = '0;
    pushWord.phase  = latDecoded_q;
    pushWord.wide   = wideS;
    pushWord.data   = wideS ? latData_q : {8'h00, latData_q[7:0]};
    pushWord.parity = latPar_q;
    pushWord.parErr = latParErr_q;
    pushWord.io     = latPhase_q[2];
    pushWord.cd     = latPhase_q[1];
    pushWord.msg    = latPhase_q[0];
    // Straight lines read at the strobe, not at the latch
    pushWord.atn    = busS.atn;
    pushWord.rst    = busS.rst;
    pushWord.bsy    = busS.bsy;
    pushWord.sel    = busS.sel;
  end

  capture_buffer u_capture_buffer (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (fireAll),
    .inReady  (bufReady),
    .inWord   (pushWord),
    .outValid (capValid),
    .outReady (capReady),
    .outWord  (capWord)
  );

  // Bus cannot be stalled; a strobe into a full buffer is flagged
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capOverrun <= 1'b0;
    end else if (fireAll && !bufReady) begin
      capOverrun <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Timing path
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timingBus <= '0;
    end else begin
      timingBus <= busS;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_lines_latched: assert property (
    latchNow |=> latData_q == $past(busS.data) && latPar_q == $past(busS.parity))
    else $error("latched group does not match bus at latch");

  chk_straight_lines: assert property (
    fireAll && !capValid |=> capWord.atn == $past(busS.atn) &&
      capWord.bsy == $past(busS.bsy) && capWord.sel == $past(busS.sel) &&
      capWord.rst == $past(busS.rst))
    else $error("straight lines not taken at strobe");

  chk_snapshot_coherent: assert property (
    fireAll && bufReady && !capValid |=> capValid && capWord.io == $past(latPhase_q[2]))
    else $error("strobe did not deliver the latched snapshot");

  chk_arb_sample: assert property (
    state_q == scsi_capture_pkg::ST_WATCH && arbBoth ##1 arbBoth[*8]
      |-> latchNow ##1 fireAll)
    else $error("arbitration sample or strobe mistimed");

  chk_sel_strobe: assert property (
    state_q == scsi_capture_pkg::ST_SEL_WAIT && bsyRise |-> fireAll)
    else $error("selection strobe missing on BSY reassert");

  chk_cmd_strobe: assert property (
    state_q == scsi_capture_pkg::ST_XFER_WAIT && kind_q == scsi_capture_pkg::PH_CMD &&
    reqFall && !ackFall |-> !edgeFire)
    else $error("command strobe taken on REQ instead of ACK");

  chk_din_strobe: assert property (
    state_q == scsi_capture_pkg::ST_XFER_WAIT && kind_q == scsi_capture_pkg::PH_DIN &&
    reqFall |-> fireAll)
    else $error("data in strobe missing on REQ negate");

  chk_dout_strobe: assert property (
    state_q == scsi_capture_pkg::ST_XFER_WAIT && kind_q == scsi_capture_pkg::PH_DOUT &&
    ackFall |-> fireAll)
    else $error("data out strobe missing on ACK negate");

  chk_free_wait: assert property (
    state_q == scsi_capture_pkg::ST_WATCH && busFree ##1 busFree[*4]
      |-> latchNow ##1 fireAll)
    else $error("bus free capture mistimed");

  chk_reset_free: assert property (
    state_q == scsi_capture_pkg::ST_FREE_DONE && busFree && rstRise |-> latchNow ##1 fireAll)
    else $error("reset during bus free not captured");

  chk_parity_gate: assert property (
    latchNow && !parEnS |=> latParErr_q == 2'h0)
    else $error("parity error set while checking disabled");

  chk_timing_pass: assert property (
    ##1 timingBus == $past(busS))
    else $error("timing path does not follow bus");

  cov_arbitration: cover property (
    state_q == scsi_capture_pkg::ST_ARB_CNT ##[1:20] state_q == scsi_capture_pkg::ST_SEL_WAIT);
  cov_data_in: cover property (
    edgeFire && kind_q == scsi_capture_pkg::PH_DIN);
  cov_reset_free: cover property (
    state_q == scsi_capture_pkg::ST_FREE_DONE && rstRise);
  cov_overrun: cover property (fireAll && !bufReady);

endmodule : scsi_phase_capture_strobe

// ===== testbench/scsi_bus_model.sv
// Model of the initiator and target seen on the observed SCSI bus.
// Assumes asserted-high levels; each change is held past the synchroniser.
`timescale 1ns/100ps
module scsi_bus_model (
  // Clock
  input  wire logic                  clk,
  // Bus levels seen by the monitor
  output scsi_capture_pkg::scsi_bus_t bus
);
  initial bus = '0;

  task automatic put(input scsi_capture_pkg::scsi_bus_t v, input int n = 5);
    @(posedge clk);
    bus <= v;
    repeat (n) @(posedge clk);
  endtask : put

  // Full handshake; data released to its inverse once ACK is up
  task automatic xfer(input logic [2:0] ph, input logic [15:0] d);
    scsi_capture_pkg::scsi_bus_t b;
    b = bus;
    {b.msg, b.cd, b.io} = ph;
    b.data = d;
    b.parity = 2'h0;
    b.atn = 1'b0;
    put(b);
    b.req = 1'b1;
    put(b);
    b.ack = 1'b1;
    put(b);
    b.data = ~d;
    b.atn = 1'b1;
    b.req = 1'b0;
    put(b);
    b.ack = 1'b0;
    put(b);
  endtask : xfer
endmodule : scsi_bus_model

// ===== testbench/testbench.sv
// Self-checking bench for the SCSI phase capture strobe block.
// Assumes the bus model drives every bus line; words taken by handshake.
`timescale 1ns/100ps
module testbench;
  logic                        clk;
  logic                        resetn;
  logic                        wideBus;
  logic                        parityCheckEn;
  logic                        capReady;
  logic                        capValid;
  logic                        capOverrun;
  scsi_capture_pkg::snapshot_t capWord;
  scsi_capture_pkg::snapshot_t w;
  scsi_capture_pkg::scsi_bus_t scsiBus;
  scsi_capture_pkg::scsi_bus_t timingBus;
  scsi_capture_pkg::scsi_bus_t b;
  int                          failures = 0;
  int                          checks_done = 0;
  int                          cyc = 0;

  scsi_bus_model bm (.clk(clk), .bus(scsiBus));
  scsi_phase_capture_strobe dut (.clk(clk), .resetn(resetn), .scsiBus(scsiBus),
    .wideBus(wideBus), .parityCheckEn(parityCheckEn), .capValid(capValid),
    .capReady(capReady), .capWord(capWord), .capOverrun(capOverrun),
    .timingBus(timingBus));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // Looks at the word between edges, then takes it in one handshake
  task automatic getw();
    int n = 0;
    @(negedge clk);
    while (capValid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("capValid", capValid, 1'b1);
    w = capWord;
    @(posedge clk);
    capReady <= 1'b1;
    @(posedge clk);
    capReady <= 1'b0;
  endtask : getw

  task automatic t_free();
    getw();
    chk("free phase", w.phase, scsi_capture_pkg::PH_FREE);
    chk("free rst", w.rst, 1'b0);
    b = scsiBus;
    b.rst = 1'b1;
    bm.put(b);
    getw();
    chk("rst phase", w.phase, scsi_capture_pkg::PH_FREE);
    chk("rst level", w.rst, 1'b1);
    $display("test free done");
  endtask : t_free

  task automatic t_arb();
    b = scsiBus;
    b.rst = 1'b0;
    b.bsy = 1'b1;
    b.sel = 1'b1;
    b.data = 16'h0080;
    bm.put(b, 12);
    chk("timingBus", timingBus, scsiBus);
    getw();
    chk("arb phase", w.phase, scsi_capture_pkg::PH_ARB);
    chk("arb lines", {w.bsy, w.sel, w.rst}, 3'h6);
    chk("arb data", w.data, 16'h0080);
    b.bsy = 1'b0;
    b.data = 16'h0041;
    bm.put(b);
    b.bsy = 1'b1;
    b.data = 16'h00BE;
    bm.put(b);
    getw();
    chk("sel phase", w.phase, scsi_capture_pkg::PH_SEL);
    chk("sel data", w.data, 16'h0041);
    b.sel = 1'b0;
    bm.put(b);
    $display("test arbitration done");
  endtask : t_arb

  task automatic t_info();
    logic [2:0] enc [6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h7, 3'h6};
    scsi_capture_pkg::phase_t ph [6] = '{scsi_capture_pkg::PH_DIN,
      scsi_capture_pkg::PH_DOUT, scsi_capture_pkg::PH_CMD,
      scsi_capture_pkg::PH_STAT, scsi_capture_pkg::PH_MSG, scsi_capture_pkg::PH_MSG};
    logic [15:0] d;
    for (int i = 0; i < 6; i++) begin
      d = 16'(16'h1357 * (i + 1));
      bm.xfer(enc[i], d);
      getw();
      chk("phase", w.phase, ph[i]);
      chk("data", w.data, d);
      chk("phase lines", {w.msg, w.cd, w.io}, enc[i]);
      chk("parErr", w.parErr, {~^d[15:8], ~^d[7:0]});
      chk("atn bsy", {w.atn, w.bsy}, 2'h3);
    end
    bm.xfer(3'h4, 16'h5A5A);
    chk("reserved word", capValid, 1'b0);
    $display("test info phases done");
  endtask : t_info

  // Narrow bus, checking off; three words while stalled, third lost
  task automatic t_stall();
    wideBus <= 1'b0;
    parityCheckEn <= 1'b0;
    for (int i = 0; i < 3; i++) bm.xfer(3'h1, 16'hA1C3 + 16'(i));
    chk("capOverrun", capOverrun, 1'b1);
    for (int i = 0; i < 2; i++) begin
      getw();
      chk("narrow data", w.data, 16'h00C3 + 16'(i));
      chk("parErr off", w.parErr, 2'h0);
    end
    $display("test stall done");
  endtask : t_stall

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2500) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    resetn = 1'b0;
    wideBus = 1'b1;
    parityCheckEn = 1'b1;
    capReady = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_free();
    t_arb();
    t_info();
    t_stall();
    stop_test();
  end
endmodule : testbench
